// ---- verilog/fabric_regs.vh ----
// Configuration bit positions, field widths and matrix source indices of the fabric slice
`ifndef FABRIC_REGS_VH
`define FABRIC_REGS_VH

// ----------------------------------------------------------------------
// Configuration store size and field widths
// ----------------------------------------------------------------------
`define CFG_MSB             2020
`define SEL_W               6
`define MX_W                64

// ----------------------------------------------------------------------
// Matrix select fields (lowest bit of each 6-bit field)
// ----------------------------------------------------------------------
`define LUT2_SEL_BASE       0
`define LUT3_SEL_BASE       48
`define LUT4_SEL_BASE       192
`define LUT4_IN2_POS        204
`define LUT4_IN3_POS        210
`define CELL_SR_BASE        216
`define CELL_LO_STEP        18
`define CELL_HI_BASE        270
`define CELL_HI_STEP        12
`define PIPE_CLK_POS        306
`define PIPE_DATA_POS       312
`define PIPE_RST_POS        318
`define INV0_SEL_POS        330
`define INV1_SEL_POS        570
`define PIN3_DOUT_POS       336
`define PIN3_OE_POS         342
`define PIN4_DOUT_POS       348
`define PIN5_DOUT_POS       354
`define PIN5_OE_POS         360
`define PIN6_DOUT_POS       366
`define PIN7_DOUT_POS       372
`define PIN7_OE_POS         378
`define PIN8_DOUT_POS       384
`define PIN9_DOUT_POS       390
`define PIN9_OE_POS         396
`define PIN10_DOUT_POS      402
`define PIN10_OE_POS        408
`define SPI_CS_POS          492
`define SPI_SCLK_POS        498
`define CROSS_BASE          510

// ----------------------------------------------------------------------
// Lookup data, pattern generator, cell option, pin 2 mode and external reset bits
// ----------------------------------------------------------------------
`define LUT2_DATA_BASE      576
`define LUT3_DATA_BASE      592
`define LUT4_DATA_POS       656
`define PATTERN_GENERATOR_LEN_POS        672
`define PATTERN_GENERATOR_MODE_POS       676
`define CELL_LO_OPT_BASE    677
`define CELL_HI_OPT_BASE    689
`define PIN2_MODE_POS       941
`define PIN2_MODE_DIGITAL   2'h0
`define XRST_TRIG_POS       2018
`define XRST_POL_POS        2019
`define XRST_EN_POS         2020

// ----------------------------------------------------------------------
// Matrix source indices
// ----------------------------------------------------------------------
`define MX_PIN2             1
`define MX_GPIO_BASE        2
`define MX_LUT2_BASE        10
`define MX_LUT3_BASE        14
`define MX_LUT4             22
`define MX_CELL_BASE        23
`define MX_INV0             29
`define MX_INV1             30
`define MX_PIPE_SHORT       31
`define MX_PIPE_LONG        32
`define MX_POR              33
`define MX_CROSS_IN_BASE    34
`define MX_ONE              63

`endif

// ---- verilog/fabric_cell.v ----
// One flip-flop/latch cell of the fabric with optional matrix set/reset
`timescale 1ns/1ps
module fabric_cell #(
   parameter HAS_SR = 1
) (
   input  wire core_clk,
   input  wire rstn,
   input  wire cell_init,
   input  wire init_val,
   input  wire mode_latch,
   input  wire out_invert,
   input  wire sr_force_one,
   input  wire sr_low,
   input  wire d_in,
   input  wire c_in,
   output wire q_out
);
   reg  q_reg;
   reg  c_prev_reg;

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q_reg      <= 1'b0;
         c_prev_reg <= 1'b0;
      end else begin
         c_prev_reg <= c_in;
         if (cell_init) begin
            q_reg <= init_val;
         end else if (HAS_SR != 0 && !sr_low) begin
            q_reg <= sr_force_one;
         end else if (mode_latch) begin
            if (c_in) begin
               q_reg <= d_in;
            end
         end else if (c_in && !c_prev_reg) begin
            q_reg <= d_in;
         end
      end
   end

   assign q_out = q_reg ^ out_invert;
endmodule // fabric_cell

// ---- verilog/fabric_slice.v ----
// Fabric slice: matrix routing, LUTs, cells, pipe delay, start-up and external reset
`timescale 1ns/1ps
`include "fabric_regs.vh"
module fabric_slice (
   input  wire              core_clk,
   input  wire              rstn,
   input  wire [`CFG_MSB:0] cfg_nvm,
   input  wire              general_input_pin,
   input  wire [7:0]        gpio_in,
   input  wire [9:0]        cross_in,
   output reg  [7:0]        gpio_out,
   output reg  [7:0]        gpio_oe_n,
   output reg  [9:0]        cross_out,
   output reg               chip_select_low,
   output reg               spi_sclk,
   output reg               por_done,
   output reg               ext_reset_active
);

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   localparam [6:0] S_LOAD  = 7'h01;
   localparam [6:0] S_PINS  = 7'h02;
   localparam [6:0] S_LUTS  = 7'h04;
   localparam [6:0] S_CELLS = 7'h08;
   localparam [6:0] S_POR   = 7'h10;
   localparam [6:0] S_RUN   = 7'h20;
   localparam [6:0] S_XRST  = 7'h40;

   reg  [`CFG_MSB:0] cfg_reg;
   reg  [6:0]        state_reg;
   reg  [6:0]        state_next;
   reg               pins_en_reg;
   reg               luts_en_reg;
   reg               cells_en_reg;
   reg               por_reg;
   reg               pins_act_reg;
   reg               pin2_prev_reg;
   reg  [8:0]        pin_in_reg;
   reg  [3:0]        lut2_reg;
   reg  [7:0]        lut3_reg;
   reg               lut4_reg;
   reg  [3:0]        pattern_generator_cnt_reg;
   reg               pattern_generator_clk_prev_reg;
   reg               pipe_clk_prev_reg;
   reg  [15:0]       pipe_reg;
   reg  [1:0]        inv_reg;
   wire [`MX_W-1:0]  mx;
   wire [5:0]        cell_q;

   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------
   function pick;
      input [`MX_W-1:0]  v;
      input [`SEL_W-1:0] s;
      begin
         pick = v[s];
      end
   endfunction

   function integer dout_pos;
      input [2:0] i;
      begin
         case (i)
            3'h0:    dout_pos = `PIN3_DOUT_POS;
            3'h1:    dout_pos = `PIN4_DOUT_POS;
            3'h2:    dout_pos = `PIN5_DOUT_POS;
            3'h3:    dout_pos = `PIN6_DOUT_POS;
            3'h4:    dout_pos = `PIN7_DOUT_POS;
            3'h5:    dout_pos = `PIN8_DOUT_POS;
            3'h6:    dout_pos = `PIN9_DOUT_POS;
            default: dout_pos = `PIN10_DOUT_POS;
         endcase
      end
   endfunction

   // Zero means the pin has no output-enable control and drives whenever active
   function integer oe_pos;
      input [2:0] i;
      begin
         case (i)
            3'h0:    oe_pos = `PIN3_OE_POS;
            3'h2:    oe_pos = `PIN5_OE_POS;
            3'h4:    oe_pos = `PIN7_OE_POS;
            3'h6:    oe_pos = `PIN9_OE_POS;
            3'h7:    oe_pos = `PIN10_OE_POS;
            default: oe_pos = 0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // External reset detection
   // ----------------------------------------------------------------------
   wire xrst_allowed = cfg_reg[`XRST_EN_POS] &&
                       (cfg_reg[`PIN2_MODE_POS +: 2] == `PIN2_MODE_DIGITAL);
   wire xrst_level   = cfg_reg[`XRST_TRIG_POS];
   wire pin2_rise    = general_input_pin && !pin2_prev_reg;
   wire pin2_fall    = !general_input_pin && pin2_prev_reg;
   wire xrst_edge    = cfg_reg[`XRST_POL_POS] ? pin2_fall : pin2_rise;
   wire xrst_hit     = xrst_allowed &&
                       (xrst_level ? general_input_pin : xrst_edge);

   // ----------------------------------------------------------------------
   // Start-up sequencer
   // ----------------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_LOAD:  state_next = S_PINS;
         S_PINS:  state_next = S_LUTS;
         S_LUTS:  state_next = S_CELLS;
         S_CELLS: state_next = S_POR;
         S_POR:   state_next = S_RUN;
         S_RUN:   state_next = xrst_hit ? S_XRST : S_RUN;
         S_XRST:  state_next = (xrst_level && xrst_hit) ? S_XRST : S_PINS;
         default: state_next = S_LOAD;
      endcase
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg        <= S_LOAD;
         cfg_reg          <= {(`CFG_MSB+1){1'b0}};
         pins_en_reg      <= 1'b0;
         luts_en_reg      <= 1'b0;
         cells_en_reg     <= 1'b0;
         por_reg          <= 1'b0;
         pins_act_reg     <= 1'b0;
         pin2_prev_reg    <= 1'b0;
         ext_reset_active <= 1'b0;
         por_done         <= 1'b0;
      end else begin
         state_reg     <= state_next;
         pin2_prev_reg <= general_input_pin;
         // Only the power-on path reloads; an external reset keeps the store
         if (state_reg == S_LOAD) begin
            cfg_reg <= cfg_nvm;
         end
         if (state_next == S_XRST) begin
            pins_en_reg  <= 1'b0;
            luts_en_reg  <= 1'b0;
            cells_en_reg <= 1'b0;
            por_reg      <= 1'b0;
         end else begin
            if (state_reg == S_PINS) begin
               pins_en_reg <= 1'b1;
            end
            if (state_reg == S_LUTS) begin
               luts_en_reg <= 1'b1;
            end
            if (state_reg == S_CELLS) begin
               cells_en_reg <= 1'b1;
            end
            if (state_reg == S_POR) begin
               por_reg      <= 1'b1;
               pins_act_reg <= 1'b1;
            end
         end
         ext_reset_active <= (state_next == S_XRST);
         por_done         <= por_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Connection matrix sources
   // ----------------------------------------------------------------------
   assign mx[0]                              = 1'b0;
   assign mx[`MX_PIN2]                       = pin_in_reg[8];
   assign mx[`MX_GPIO_BASE +: 8]             = pin_in_reg[7:0];
   assign mx[`MX_LUT2_BASE +: 4]             = lut2_reg;
   assign mx[`MX_LUT3_BASE +: 8]             = lut3_reg;
   assign mx[`MX_LUT4]                       = lut4_reg;
   assign mx[`MX_CELL_BASE +: 6]             = cell_q;
   assign mx[`MX_INV0]                       = inv_reg[0];
   assign mx[`MX_INV1]                       = inv_reg[1];
   assign mx[`MX_PIPE_SHORT]                 = pipe_reg[0];
   assign mx[`MX_PIPE_LONG]                  = pipe_reg[15];
   assign mx[`MX_POR]                        = por_reg;
   assign mx[`MX_CROSS_IN_BASE +: 10]        = cross_in;
   assign mx[`MX_ONE-1:`MX_CROSS_IN_BASE+10] = {(`MX_ONE-`MX_CROSS_IN_BASE-10){1'b0}};
   assign mx[`MX_ONE]                        = 1'b1;

   // Every cell output is registered, so a routing loop never becomes a
   // combinational loop; the price is one cycle of latency per hop.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_in_reg <= 9'h000;
         inv_reg    <= 2'h0;
      end else begin
         pin_in_reg <= pins_en_reg ? {general_input_pin, gpio_in} : 9'h000;
         inv_reg[0] <= ~pick(mx, cfg_reg[`INV0_SEL_POS +: `SEL_W]);
         inv_reg[1] <= ~pick(mx, cfg_reg[`INV1_SEL_POS +: `SEL_W]);
      end
   end

   // ----------------------------------------------------------------------
   // Lookup tables
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lut2
         wire [1:0] idx = {pick(mx, cfg_reg[`LUT2_SEL_BASE + 12*g + 6 +: `SEL_W]),
                           pick(mx, cfg_reg[`LUT2_SEL_BASE + 12*g +: `SEL_W])};
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               lut2_reg[g] <= 1'b0;
            end else begin
               lut2_reg[g] <= luts_en_reg & cfg_reg[`LUT2_DATA_BASE + 4*g + idx];
            end
         end
      end
      for (g = 0; g < 8; g = g + 1) begin : g_lut3
         wire [2:0] idx = {pick(mx, cfg_reg[`LUT3_SEL_BASE + 18*g + 12 +: `SEL_W]),
                           pick(mx, cfg_reg[`LUT3_SEL_BASE + 18*g + 6 +: `SEL_W]),
                           pick(mx, cfg_reg[`LUT3_SEL_BASE + 18*g +: `SEL_W])};
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               lut3_reg[g] <= 1'b0;
            end else begin
               lut3_reg[g] <= luts_en_reg & cfg_reg[`LUT3_DATA_BASE + 8*g + idx];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Four-input LUT or pattern generator
   // ----------------------------------------------------------------------
   wire       lut4_in0  = pick(mx, cfg_reg[`LUT4_SEL_BASE +: `SEL_W]);
   wire       lut4_in1  = pick(mx, cfg_reg[`LUT4_SEL_BASE + 6 +: `SEL_W]);
   wire       lut4_in2  = pick(mx, cfg_reg[`LUT4_IN2_POS +: `SEL_W]);
   wire       lut4_in3  = pick(mx, cfg_reg[`LUT4_IN3_POS +: `SEL_W]);
   wire       pattern_generator_mode = cfg_reg[`PATTERN_GENERATOR_MODE_POS];
   wire [3:0] pattern_generator_len  = cfg_reg[`PATTERN_GENERATOR_LEN_POS +: 4];
   wire       pattern_gen_reset_low = lut4_in3;
   wire [3:0] lut4_idx  = pattern_generator_mode ? pattern_generator_cnt_reg
                                    : {lut4_in3, lut4_in2, lut4_in1, lut4_in0};

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pattern_generator_cnt_reg      <= 4'h0;
         pattern_generator_clk_prev_reg <= 1'b0;
         lut4_reg          <= 1'b0;
      end else begin
         pattern_generator_clk_prev_reg <= lut4_in2;
         lut4_reg          <= luts_en_reg & cfg_reg[`LUT4_DATA_POS + lut4_idx];
         if (!cells_en_reg || !pattern_generator_mode || !pattern_gen_reset_low) begin
            pattern_generator_cnt_reg <= 4'h0;
         end else if (lut4_in2 && !pattern_generator_clk_prev_reg) begin
            // Counter wraps after reaching the programmed length
            pattern_generator_cnt_reg <= (pattern_generator_cnt_reg >= pattern_generator_len) ? 4'h0
                                                       : pattern_generator_cnt_reg + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Flip-flop/latch cells
   // ----------------------------------------------------------------------
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_cell_sr
         fabric_cell #(
            .HAS_SR (1)
         ) u_cell (
            .core_clk     (core_clk),
            .rstn         (rstn),
            .cell_init    (!cells_en_reg),
            .init_val     (cfg_reg[`CELL_LO_OPT_BASE + 4*g + 3]),
            .mode_latch   (cfg_reg[`CELL_LO_OPT_BASE + 4*g]),
            .out_invert   (cfg_reg[`CELL_LO_OPT_BASE + 4*g + 1]),
            .sr_force_one (cfg_reg[`CELL_LO_OPT_BASE + 4*g + 2]),
            .sr_low       (pick(mx, cfg_reg[`CELL_SR_BASE + `CELL_LO_STEP*g +: `SEL_W])),
            .d_in         (pick(mx, cfg_reg[`CELL_SR_BASE + `CELL_LO_STEP*g + 6 +: `SEL_W])),
            .c_in         (pick(mx, cfg_reg[`CELL_SR_BASE + `CELL_LO_STEP*g + 12 +: `SEL_W])),
            .q_out        (cell_q[g])
         );
      end
      for (g = 0; g < 3; g = g + 1) begin : g_cell_plain
         fabric_cell #(
            .HAS_SR (0)
         ) u_cell (
            .core_clk     (core_clk),
            .rstn         (rstn),
            .cell_init    (!cells_en_reg),
            .init_val     (cfg_reg[`CELL_HI_OPT_BASE + 3*g + 2]),
            .mode_latch   (cfg_reg[`CELL_HI_OPT_BASE + 3*g]),
            .out_invert   (cfg_reg[`CELL_HI_OPT_BASE + 3*g + 1]),
            .sr_force_one (1'b0),
            .sr_low       (1'b1),
            .d_in         (pick(mx, cfg_reg[`CELL_HI_BASE + `CELL_HI_STEP*g +: `SEL_W])),
            .c_in         (pick(mx, cfg_reg[`CELL_HI_BASE + `CELL_HI_STEP*g + 6 +: `SEL_W])),
            .q_out        (cell_q[g+3])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Pipe delay
   // ----------------------------------------------------------------------
   wire pipe_clk  = pick(mx, cfg_reg[`PIPE_CLK_POS +: `SEL_W]);
   wire pipe_data = pick(mx, cfg_reg[`PIPE_DATA_POS +: `SEL_W]);
   wire pipe_rst  = pick(mx, cfg_reg[`PIPE_RST_POS +: `SEL_W]);

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pipe_reg          <= 16'h0000;
         pipe_clk_prev_reg <= 1'b0;
      end else begin
         pipe_clk_prev_reg <= pipe_clk;
         if (!cells_en_reg || pipe_rst) begin
            pipe_reg <= 16'h0000;
         end else if (pipe_clk && !pipe_clk_prev_reg) begin
            pipe_reg <= {pipe_reg[14:0], pipe_data};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pins, cross links and serial port taps
   // ----------------------------------------------------------------------
   integer k;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gpio_out        <= 8'h00;
         gpio_oe_n       <= 8'hff;
         cross_out       <= 10'h000;
         chip_select_low <= 1'b1;
         spi_sclk        <= 1'b0;
      end else begin
         for (k = 0; k < 8; k = k + 1) begin
            gpio_out[k] <= pick(mx, cfg_reg[dout_pos(k[2:0]) +: `SEL_W]);
            // Pins stay released only until start-up ends; an external reset
            // leaves them under their enable logic
            if (!pins_act_reg) begin
               gpio_oe_n[k] <= 1'b1;
            end else if (oe_pos(k[2:0]) == 0) begin
               gpio_oe_n[k] <= 1'b0;
            end else begin
               gpio_oe_n[k] <= ~pick(mx, cfg_reg[oe_pos(k[2:0]) +: `SEL_W]);
            end
         end
         for (k = 0; k < 10; k = k + 1) begin
            cross_out[k] <= pick(mx, cfg_reg[`CROSS_BASE + 6*k +: `SEL_W]);
         end
         chip_select_low <= pick(mx, cfg_reg[`SPI_CS_POS +: `SEL_W]);
         spi_sclk        <= pick(mx, cfg_reg[`SPI_SCLK_POS +: `SEL_W]);
      end
   end

endmodule // fabric_slice

// ---- verif/fabric_slice_monitor.sv ----
// Assertion checker bound to the fabric slice ports
`timescale 1ns/1ps
`include "fabric_regs.vh"
module fabric_slice_monitor (
   input wire              core_clk,
   input wire              rstn,
   input wire [`CFG_MSB:0] cfg_nvm,
   input wire              general_input_pin,
   input wire [7:0]        gpio_in,
   input wire [9:0]        cross_in,
   input wire [7:0]        gpio_out,
   input wire [7:0]        gpio_oe_n,
   input wire [9:0]        cross_out,
   input wire              chip_select_low,
   input wire              spi_sclk,
   input wire              por_done,
   input wire              ext_reset_active
);
   // ---------------
   // Helpers
   // ---------------
   wire xen = cfg_nvm[`XRST_EN_POS] && cfg_nvm[`PIN2_MODE_POS+:2] == `PIN2_MODE_DIGITAL;
   wire trg = cfg_nvm[`XRST_TRIG_POS];
   wire pol = cfg_nvm[`XRST_POL_POS];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ---------------
   // Properties
   // ---------------
   property p_start; $rose(rstn) |-> !por_done [*4] ##[1:6] por_done; endproperty
   a_start: assert property (p_start) else $error("start flag late");
   property p_hiz; $rose(rstn) |-> (gpio_oe_n == 8'hff) [*5]; endproperty
   a_hiz: assert property (p_hiz) else $error("pins early");
   property p_gate; !xen |-> !ext_reset_active; endproperty
   a_gate: assert property (p_gate) else $error("reset not gated");
   property p_level; xen && trg && por_done && general_input_pin |-> ##[1:3] ext_reset_active;
   endproperty
   a_level: assert property (p_level) else $error("level missed");
   property p_rise; xen && !trg && !pol && por_done && $rose(general_input_pin)
      |-> ##[1:3] ext_reset_active; endproperty
   a_rise: assert property (p_rise) else $error("rise missed");
   property p_fall; xen && !trg && pol && por_done && $fell(general_input_pin)
      |-> ##[1:3] ext_reset_active; endproperty
   a_fall: assert property (p_fall) else $error("fall missed");
   property p_oe; ext_reset_active && cfg_nvm[`PIN3_OE_POS+:6] == 6'h3f |-> !gpio_oe_n[0];
   endproperty
   a_oe: assert property (p_oe) else $error("pin released");
   property p_back; $fell(ext_reset_active) |-> ##[1:10] por_done; endproperty
   a_back: assert property (p_back) else $error("no restart");
   c_level: cover property (xen && trg && ext_reset_active);
   c_edge: cover property (xen && !trg && ext_reset_active);
   c_run: cover property ($rose(por_done));
endmodule // fabric_slice_monitor
bind fabric_slice fabric_slice_monitor u_mon (.core_clk, .rstn, .cfg_nvm, .general_input_pin,
   .gpio_in, .cross_in, .gpio_out, .gpio_oe_n, .cross_out, .chip_select_low, .spi_sclk,
   .por_done, .ext_reset_active);

// ---- verif/reset_source.sv ----
// Model of the outside logic driving the reset input pin
`timescale 1ns/1ps
module reset_source (
   input  wire core_clk,
   output reg  pin
);
   // ---------------
   // Drive task
   // ---------------
   initial pin = 1'b0;
   // Moves only just after an edge, so no half-cycle glitch
   task automatic hold(input logic lvl, input int n);
      pin <= lvl;
      repeat (n) @(posedge core_clk);
   endtask
endmodule // reset_source

// ---- verif/fabric_slice_test.sv ----
// Self-checking bench of the fabric slice
`timescale 1ns/1ps
`include "fabric_regs.vh"
module fabric_slice_test;
   // ---------------
   // Signals
   // ---------------
   reg              core_clk;
   reg              rstn;
   reg [`CFG_MSB:0] cfg_nvm;
   reg [`CFG_MSB:0] c;
   reg [7:0]        gpio_in;
   reg [9:0]        cross_in;
   reg              seen;
   wire             pin2;
   wire [7:0]       gpio_out;
   wire [7:0]       gpio_oe_n;
   wire [9:0]       cross_out;
   wire             chip_select_low;
   wire             spi_sclk;
   wire             por_done;
   wire             ext_reset_active;
   int              failures;
   int              checks_done;
   int              cycles;
   // Select, input, cell options, set/reset, cell clock, table data, result
   typedef struct packed {
      logic [5:0] sel; logic din; logic [3:0] opt; logic [5:0] sr;
      logic [5:0] ck; logic [15:0] lut; logic exp;
   } row_t;
   row_t rows [13] = '{
      {6'h00,1'b1,4'h0,6'h3f,6'h00,16'h0,1'b0},
      {6'h3f,1'b0,4'h0,6'h3f,6'h00,16'h0,1'b1},
      {6'h02,1'b1,4'h0,6'h3f,6'h00,16'h0,1'b1},
      {6'h22,1'b1,4'h0,6'h3f,6'h00,16'h0,1'b1},
      {6'h1d,1'b1,4'h0,6'h3f,6'h00,16'h0,1'b0},
      {6'h1e,1'b0,4'h0,6'h3f,6'h00,16'h0,1'b0},
      {6'h17,1'b0,4'h8,6'h3f,6'h00,16'h0,1'b1},
      {6'h17,1'b0,4'ha,6'h3f,6'h00,16'h0,1'b0},
      {6'h17,1'b0,4'h4,6'h00,6'h00,16'h0,1'b1},
      {6'h17,1'b0,4'h8,6'h00,6'h00,16'h0,1'b0},
      {6'h17,1'b1,4'h1,6'h3f,6'h3f,16'h0,1'b1},
      {6'h17,1'b0,4'h9,6'h3f,6'h3f,16'h0,1'b0},
      {6'h16,1'b0,4'h0,6'h3f,6'h00,16'h0001,1'b1}
   };
   fabric_slice u_dut (.core_clk(core_clk), .rstn(rstn), .cfg_nvm(cfg_nvm),
      .general_input_pin(pin2), .gpio_in(gpio_in), .cross_in(cross_in),
      .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .cross_out(cross_out),
      .chip_select_low(chip_select_low), .spi_sclk(spi_sclk), .por_done(por_done),
      .ext_reset_active(ext_reset_active));
   reset_source u_src (.core_clk(core_clk), .pin(pin2));
   // ---------------
   // Tasks
   // ---------------
   function automatic logic [`CFG_MSB:0] base(input logic [5:0] s);
      logic [`CFG_MSB:0] v;
      v = '0;
      v[`PIN3_DOUT_POS+:6] = s;
      v[`PIN3_OE_POS+:6] = 6'h3f;
      v[`CROSS_BASE+:6] = s;
      v[`SPI_CS_POS+:6] = s;
      v[`SPI_SCLK_POS+:6] = s;
      v[`INV0_SEL_POS+:6] = 6'h02;
      v[`INV1_SEL_POS+:6] = 6'h3f;
      v[`CELL_SR_BASE+6+:6] = 6'h02;
      return v;
   endfunction
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic boot(input logic [`CFG_MSB:0] cfg);
      rstn <= 1'b0;
      cfg_nvm <= cfg;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (20) @(posedge core_clk);
   endtask
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------
   // Clock, watch and sequence
   // ---------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (ext_reset_active)
         seen <= 1'b1;
      if (cycles == 3000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      rstn = 1'b0;
      cfg_nvm = '0;
      gpio_in = 8'h00;
      cross_in = 10'h000;
      seen = 1'b0;
      foreach (rows[i]) begin
         c = base(rows[i].sel);
         c[`CELL_LO_OPT_BASE+:4] = rows[i].opt;
         c[`CELL_SR_BASE+:6] = rows[i].sr;
         c[`CELL_SR_BASE+12+:6] = rows[i].ck;
         c[`LUT4_DATA_POS+:16] = rows[i].lut;
         gpio_in <= {7'h00, rows[i].din};
         cross_in <= {9'h000, rows[i].din};
         boot(c);
         check(10'({gpio_out[0], cross_out[0], chip_select_low, spi_sclk}),
               10'({4{rows[i].exp}}));
         check(10'(gpio_oe_n), 10'h0d4);
      end
      // Level, rising, falling, disabled, pin not digital
      for (int m = 0; m < 5; m++) begin
         c = base(6'h02);
         c[`XRST_EN_POS] = (m != 3);
         c[`XRST_TRIG_POS] = (m == 0);
         c[`XRST_POL_POS] = (m == 2);
         c[`PIN2_MODE_POS] = (m == 4);
         gpio_in <= 8'h01;
         u_src.hold(m == 2, 1);
         boot(c);
         seen = 1'b0;
         u_src.hold(m != 2, 4);
         u_src.hold(m == 2, 20);
         check(10'({seen, por_done, gpio_out[0]}), 10'({m < 3, 2'b11}));
      end
      // Pipe stage 1 on pin 3, edge cell 0 on pin 4, plain cell 3 on pin 6
      c = base(6'h1f);
      c[`PIN4_DOUT_POS+:6] = 6'h17;
      c[`PIN6_DOUT_POS+:6] = 6'h1a;
      c[`CELL_SR_BASE+:6] = 6'h3f;
      c[`CELL_SR_BASE+12+:6] = 6'h03;
      c[`CELL_HI_OPT_BASE+:3] = 3'h4;
      c[`PIPE_CLK_POS+:6] = 6'h03;
      c[`PIPE_DATA_POS+:6] = 6'h02;
      gpio_in <= 8'h01;
      boot(c);
      check(10'({gpio_out[3], gpio_out[1], gpio_out[0]}), 10'h004);
      gpio_in <= 8'h03;
      repeat (5) @(posedge core_clk);
      check(10'({gpio_out[3], gpio_out[1], gpio_out[0]}), 10'h007);
      c = base(6'h16);
      c[`PATTERN_GENERATOR_MODE_POS] = 1'b1;
      c[`PATTERN_GENERATOR_LEN_POS+:4] = 4'h2;
      c[`LUT4_DATA_POS+:16] = 16'h0005;
      c[`LUT4_IN2_POS+:6] = 6'h03;
      c[`LUT4_IN3_POS+:6] = 6'h04;
      gpio_in <= 8'h04;
      boot(c);
      for (int k = 0; k < 4; k++) begin
         check(10'(gpio_out[0]), 10'((k % 3) != 1));
         gpio_in <= 8'h06;
         repeat (4) @(posedge core_clk);
         gpio_in <= 8'h04;
         repeat (4) @(posedge core_clk);
      end
      gpio_in <= 8'h00;
      // Input, counter, table and pin stages: four edges, read on the fifth
      repeat (5) @(posedge core_clk);
      check(10'(gpio_out[0]), 10'h001);
      final_report();
   end
endmodule // fabric_slice_test
